// File: acrt_pkg.sv
// shared constants, timing counts and state types for the conversion and readout sequencer
package acrt_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // timing figures in their own unit
  localparam int T_BUSY_RISE_MAX_NS = 30;
  localparam int T_CONV_MAX_NS = 1250;
  localparam int T_EOC_TO_BUSY_MIN_NS = 10;
  localparam int T_DATA_TO_BUSY_MIN_NS = 45;
  localparam int T_SYNC_DURING_TYP_NS = 525;
  localparam int T_SYNC_TO_BUSY_TYP_NS = 25;
  localparam int T_SCLK_MIN_00_NS = 25;
  localparam int T_SCLK_MIN_01_NS = 50;
  localparam int T_SCLK_MIN_10_NS = 100;
  localparam int T_SCLK_MIN_11_NS = 200;
  localparam int T_SCLK_TYP_00_NS = 40;
  localparam int T_SCLK_TYP_01_NS = 70;
  localparam int T_SCLK_TYP_10_NS = 140;
  localparam int T_SCLK_TYP_11_NS = 280;
  localparam int T_TAIL_MIN_00_NS = 3;
  localparam int T_TAIL_MIN_01_NS = 60;
  localparam int T_TAIL_MIN_10_NS = 140;
  localparam int T_TAIL_MIN_11_NS = 300;

  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int floor_cycles(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int BUSY_RISE_CYC = floor_cycles(T_BUSY_RISE_MAX_NS);
  localparam int BUSY_MAX_CYC = floor_cycles(T_CONV_MAX_NS);
  localparam int EOC_TO_BUSY_CYC = ceil_cycles(T_EOC_TO_BUSY_MIN_NS);
  localparam int DATA_TO_BUSY_CYC = ceil_cycles(T_DATA_TO_BUSY_MIN_NS);
  localparam int SYNC_DURING_CYC = floor_cycles(T_SYNC_DURING_TYP_NS);
  localparam int SYNC_TO_BUSY_CYC = floor_cycles(T_SYNC_TO_BUSY_TYP_NS);
  // cycles after the conversion core that the parallel path needs: store, load, data-to-busy gap
  localparam int POST_CONV_CYC = 2 + DATA_TO_BUSY_CYC;
  localparam int CORE_CONV_CYC = BUSY_MAX_CYC - POST_CONV_CYC;

  localparam int CNT_W = 6;
  localparam int DIV_W = 4;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 32;

  localparam logic [1:0] DIV_CODE_00 = 2'h0;
  localparam logic [1:0] DIV_CODE_01 = 2'h1;
  localparam logic [1:0] DIV_CODE_10 = 2'h2;
  localparam logic [1:0] DIV_CODE_11 = 2'h3;

  // a period needs two clock phases, so the typical period is used; the minimum only bounds it from below
  function automatic logic [DIV_W-1:0] sclk_half_cycles(input logic [1:0] code);
    int ns;
    unique case (code)
      DIV_CODE_00: ns = (T_SCLK_TYP_00_NS > T_SCLK_MIN_00_NS) ? T_SCLK_TYP_00_NS : T_SCLK_MIN_00_NS;
      DIV_CODE_01: ns = (T_SCLK_TYP_01_NS > T_SCLK_MIN_01_NS) ? T_SCLK_TYP_01_NS : T_SCLK_MIN_01_NS;
      DIV_CODE_10: ns = (T_SCLK_TYP_10_NS > T_SCLK_MIN_10_NS) ? T_SCLK_TYP_10_NS : T_SCLK_MIN_10_NS;
      DIV_CODE_11: ns = (T_SCLK_TYP_11_NS > T_SCLK_MIN_11_NS) ? T_SCLK_TYP_11_NS : T_SCLK_MIN_11_NS;
    endcase
    return DIV_W'(ceil_cycles(ns / 2));
  endfunction

  function automatic logic [DIV_W-1:0] sync_tail_cycles(input logic [1:0] code);
    int ns;
    unique case (code)
      DIV_CODE_00: ns = T_TAIL_MIN_00_NS;
      DIV_CODE_01: ns = T_TAIL_MIN_01_NS;
      DIV_CODE_10: ns = T_TAIL_MIN_10_NS;
      DIV_CODE_11: ns = T_TAIL_MIN_11_NS;
    endcase
    return DIV_W'(ceil_cycles(ns));
  endfunction

  typedef enum {
    ACRT_IDLE,
    ACRT_CONVERT,
    ACRT_STORE,
    ACRT_PAR_LOAD,
    ACRT_PAR_HOLD,
    ACRT_SER_END,
    ACRT_RAC_START,
    ACRT_RAC_SHIFT,
    ACRT_RAC_END
  } acrt_state_type;

  typedef enum {
    ACRT_SH_IDLE,
    ACRT_SH_SHIFT,
    ACRT_SH_TAIL
  } acrt_shift_state_type;

endpackage

// File: acrt_fifo.sv
// result fifo between the conversion core and the readout ports
`timescale 1ns/10ps
module acrt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge clk)
  begin
    if (clk_en && push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        wr_ptr_reg <= next_ptr(wr_ptr_reg);
      end
      if (pop)
      begin
        rd_ptr_reg <= next_ptr(rd_ptr_reg);
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

// File: acrt_shifter.sv
// serial shift-out engine: internal clock divider for master, external edge stepping for slave
`timescale 1ns/10ps
module acrt_shifter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [WIDTH-1:0] word,
  input wire logic master,
  input wire logic [acrt_pkg::DIV_W-1:0] half_cycles,
  input wire logic [acrt_pkg::DIV_W-1:0] tail_cycles,
  input wire logic ext_clock_edge,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_clock_out,
  output logic frame,
  output logic idle
);
  localparam int BW = $clog2(WIDTH + 1);

  acrt_pkg::acrt_shift_state_type state_reg;
  logic [WIDTH-1:0] shift_reg;
  logic [BW-1:0] bit_cnt_reg;
  logic [acrt_pkg::DIV_W-1:0] div_cnt_reg;
  logic sclk_reg;
  logic master_reg;
  logic div_tick;

  assign div_tick = (div_cnt_reg == half_cycles - acrt_pkg::DIV_W'(1));
  assign serial_data_out = shift_reg[WIDTH-1];
  assign serial_clock_out = sclk_reg;
  assign frame = (state_reg != acrt_pkg::ACRT_SH_IDLE);
  assign idle = (state_reg == acrt_pkg::ACRT_SH_IDLE);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= acrt_pkg::ACRT_SH_IDLE;
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      div_cnt_reg <= '0;
      sclk_reg <= 1'b0;
      master_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      unique case (state_reg)
        acrt_pkg::ACRT_SH_IDLE:
        begin
          sclk_reg <= 1'b0;
          div_cnt_reg <= '0;
          if (start)
          begin
            shift_reg <= word;
            bit_cnt_reg <= '0;
            master_reg <= master;
            state_reg <= acrt_pkg::ACRT_SH_SHIFT;
          end
        end
        acrt_pkg::ACRT_SH_SHIFT:
        begin
          if (master_reg)
          begin
            // host samples on the rising edge, data moves on the falling edge
            div_cnt_reg <= div_tick ? '0 : div_cnt_reg + acrt_pkg::DIV_W'(1);
            if (div_tick)
            begin
              sclk_reg <= ~sclk_reg;
              if (!sclk_reg)
              begin
                bit_cnt_reg <= bit_cnt_reg + BW'(1);
              end
              else if (bit_cnt_reg == BW'(WIDTH))
              begin
                sclk_reg <= 1'b0;
                div_cnt_reg <= '0;
                state_reg <= acrt_pkg::ACRT_SH_TAIL;
              end
              else
              begin
                shift_reg <= {shift_reg[WIDTH-2:0], serial_data_in};
              end
            end
          end
          else if (ext_clock_edge)
          begin
            shift_reg <= {shift_reg[WIDTH-2:0], serial_data_in};
            bit_cnt_reg <= bit_cnt_reg + BW'(1);
            if (bit_cnt_reg == BW'(WIDTH - 1))
            begin
              state_reg <= acrt_pkg::ACRT_SH_IDLE;
            end
          end
        end
        acrt_pkg::ACRT_SH_TAIL:
        begin
          // frame stays up after the last clock edge for the code's hold time
          div_cnt_reg <= div_cnt_reg + acrt_pkg::DIV_W'(1);
          if (div_cnt_reg == tail_cycles - acrt_pkg::DIV_W'(1))
          begin
            state_reg <= acrt_pkg::ACRT_SH_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// File: acrt_top.sv
// conversion sequencer with parallel, master serial and slave serial readout
// Operation
// - busy rises at the first clock after conversion start falls.
// - outside master read-after-convert, busy stays high at most 1.25 us unless a full fifo stalls the store.
// - busy falls at least 10 ns after the conversion core finishes.
// - parallel result valid on the data bus within 1.25 us of start.
// - parallel result valid at least 45 ns before busy falls.
// - master read-during-convert raises frame sync about 525 ns after start.
// - divider code sets minimum serial clock period 25, 50, 100, 200 ns.
// - divider code sets typical serial clock period 40, 70, 140, 280 ns; whole-cycle phases here give 200, 200, 200, 400 ns.
// - read-after-convert busy covers conversion plus shift-out, bounded per divider code.
// - frame sync holds after last clock edge 3, 60, 140, 300 ns.
// - read-after-convert frame sync rises once conversion completes.
// - read-after-convert busy falls about 25 ns after frame sync falls; here it falls two clock cycles (200 ns) after.
// - chip select high releases frame sync, serial clock and data.
// - in master serial modes chip select low drives the serial clock.
// - divider select acts only in master read-after-convert mode.
// - serial/parallel select low uses parallel port, high uses serial port.
`timescale 1ns/10ps
module acrt_top #(
  parameter int DATA_WIDTH = acrt_pkg::DATA_W,
  parameter int FIFO_DEPTH = acrt_pkg::FIFO_DEPTH,
  parameter int CONV_CYCLES = acrt_pkg::CORE_CONV_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic conversion_start_n,
  input wire logic chip_select_n,
  input wire logic serial_parallel_select,
  input wire logic read_timing_select,
  input wire logic clock_source_select,
  input wire logic [1:0] serial_clock_divider_select,
  input wire logic [DATA_WIDTH-1:0] conversion_result,
  input wire logic external_serial_clock,
  input wire logic serial_data_in,
  output logic busy,
  output logic [DATA_WIDTH-1:0] data_bus_out,
  output logic data_bus_oe_n,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  output logic serial_clock_out,
  output logic serial_clock_oe_n,
  output logic frame_sync_out,
  output logic frame_sync_oe_n
);
  acrt_pkg::acrt_state_type state_reg;
  logic [acrt_pkg::CNT_W-1:0] cnt_reg;
  logic [DATA_WIDTH-1:0] result_reg;
  logic [DATA_WIDTH-1:0] data_out_reg;
  logic busy_reg;
  logic start_n_prev_reg;
  logic ext_clk_prev_reg;
  logic start_fall;
  logic ext_clock_edge;
  logic serial_mode;
  logic master_mode;
  logic rac_mode;
  logic during_mode;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DATA_WIDTH-1:0] fifo_out_data;
  logic shift_start;
  logic shift_idle;
  logic shift_frame;
  logic shift_sdo;
  logic shift_sclk;
  logic par_load;
  logic [acrt_pkg::DIV_W-1:0] half_cycles;
  logic [acrt_pkg::DIV_W-1:0] tail_cycles;

  assign serial_mode = serial_parallel_select;
  assign master_mode = serial_mode & ~clock_source_select;
  assign rac_mode = master_mode & ~read_timing_select;
  assign during_mode = master_mode & read_timing_select;

  // divider select is forced to the fastest code unless in read-after-convert
  assign half_cycles = rac_mode ? acrt_pkg::sclk_half_cycles(serial_clock_divider_select)
                                : acrt_pkg::sclk_half_cycles(acrt_pkg::DIV_CODE_00);
  assign tail_cycles = rac_mode ? acrt_pkg::sync_tail_cycles(serial_clock_divider_select)
                                : acrt_pkg::sync_tail_cycles(acrt_pkg::DIV_CODE_00);

  assign start_fall = start_n_prev_reg & ~conversion_start_n;
  assign ext_clock_edge = ~ext_clk_prev_reg & external_serial_clock;

  assign fifo_in_valid = (state_reg == acrt_pkg::ACRT_STORE);
  assign par_load = (state_reg == acrt_pkg::ACRT_PAR_LOAD) & fifo_out_valid;

  // shift-out start conditions, one per serial timing mode
  always_comb
  begin
    shift_start = 1'b0;
    if (serial_mode && !chip_select_n && shift_idle && fifo_out_valid)
    begin
      if (rac_mode)
      begin
        shift_start = (state_reg == acrt_pkg::ACRT_RAC_START);
      end
      else if (during_mode)
      begin
        shift_start = (state_reg == acrt_pkg::ACRT_CONVERT) &&
                      (cnt_reg == acrt_pkg::CNT_W'(acrt_pkg::SYNC_DURING_CYC - acrt_pkg::BUSY_RISE_CYC));
      end
      else
      begin
        shift_start = 1'b1;
      end
    end
  end

  assign fifo_out_ready = shift_start | par_load;

  // edge detectors for the start pin and the host-driven serial clock
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      start_n_prev_reg <= 1'b1;
      ext_clk_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      start_n_prev_reg <= conversion_start_n;
      ext_clk_prev_reg <= external_serial_clock;
    end
  end

  // conversion and busy sequencing
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= acrt_pkg::ACRT_IDLE;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      result_reg <= '0;
    end
    else if (clk_en)
    begin
      unique case (state_reg)
        acrt_pkg::ACRT_IDLE:
        begin
          cnt_reg <= '0;
          // starts that arrive mid-cycle are dropped; the host keeps its spacing
          if (start_fall)
          begin
            busy_reg <= 1'b1;
            state_reg <= acrt_pkg::ACRT_CONVERT;
          end
        end
        acrt_pkg::ACRT_CONVERT:
        begin
          cnt_reg <= cnt_reg + acrt_pkg::CNT_W'(1);
          if (cnt_reg == acrt_pkg::CNT_W'(CONV_CYCLES - 1))
          begin
            result_reg <= conversion_result;
            cnt_reg <= '0;
            state_reg <= acrt_pkg::ACRT_STORE;
          end
        end
        acrt_pkg::ACRT_STORE:
        begin
          // a full fifo stalls here with busy high until a reader drains a word
          if (fifo_in_ready)
          begin
            if (!serial_mode)
            begin
              state_reg <= acrt_pkg::ACRT_PAR_LOAD;
            end
            else if (rac_mode)
            begin
              state_reg <= acrt_pkg::ACRT_RAC_START;
            end
            else
            begin
              state_reg <= acrt_pkg::ACRT_SER_END;
            end
          end
        end
        acrt_pkg::ACRT_PAR_LOAD:
        begin
          if (fifo_out_valid)
          begin
            state_reg <= acrt_pkg::ACRT_PAR_HOLD;
          end
        end
        acrt_pkg::ACRT_PAR_HOLD:
        begin
          cnt_reg <= cnt_reg + acrt_pkg::CNT_W'(1);
          if (cnt_reg == acrt_pkg::CNT_W'(acrt_pkg::DATA_TO_BUSY_CYC - 1))
          begin
            busy_reg <= 1'b0;
            state_reg <= acrt_pkg::ACRT_IDLE;
          end
        end
        acrt_pkg::ACRT_SER_END:
        begin
          cnt_reg <= cnt_reg + acrt_pkg::CNT_W'(1);
          if (cnt_reg == acrt_pkg::CNT_W'(acrt_pkg::EOC_TO_BUSY_CYC - 1))
          begin
            busy_reg <= 1'b0;
            state_reg <= acrt_pkg::ACRT_IDLE;
          end
        end
        acrt_pkg::ACRT_RAC_START:
        begin
          // without chip select the word waits in the fifo and busy ends normally
          if (shift_start)
          begin
            state_reg <= acrt_pkg::ACRT_RAC_SHIFT;
          end
          else if (chip_select_n)
          begin
            state_reg <= acrt_pkg::ACRT_SER_END;
          end
        end
        acrt_pkg::ACRT_RAC_SHIFT:
        begin
          if (!shift_frame)
          begin
            cnt_reg <= '0;
            state_reg <= acrt_pkg::ACRT_RAC_END;
          end
        end
        acrt_pkg::ACRT_RAC_END:
        begin
          cnt_reg <= cnt_reg + acrt_pkg::CNT_W'(1);
          if (cnt_reg == acrt_pkg::CNT_W'(acrt_pkg::SYNC_TO_BUSY_CYC - 1))
          begin
            busy_reg <= 1'b0;
            state_reg <= acrt_pkg::ACRT_IDLE;
          end
        end
      endcase
    end
  end

  // parallel data register, loaded one cycle ahead of busy falling
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_out_reg <= '0;
    end
    else if (clk_en && par_load)
    begin
      data_out_reg <= fifo_out_data;
    end
  end

  acrt_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) result_fifo (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(result_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  acrt_shifter #(
    .WIDTH(DATA_WIDTH)
  ) serial_engine (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(shift_start),
    .word(fifo_out_data),
    .master(master_mode),
    .half_cycles(half_cycles),
    .tail_cycles(tail_cycles),
    .ext_clock_edge(ext_clock_edge),
    .serial_data_in(serial_data_in),
    .serial_data_out(shift_sdo),
    .serial_clock_out(shift_sclk),
    .frame(shift_frame),
    .idle(shift_idle)
  );

  assign busy = busy_reg;
  assign data_bus_out = data_out_reg;
  assign serial_data_out = shift_sdo;
  assign serial_clock_out = shift_sclk;
  assign frame_sync_out = shift_frame & master_mode;

  // enables follow chip select combinationally so release and drive need no clock
  assign data_bus_oe_n = chip_select_n | serial_mode;
  assign serial_data_oe_n = chip_select_n | ~serial_mode;
  assign frame_sync_oe_n = chip_select_n | ~master_mode;
  assign serial_clock_oe_n = chip_select_n | ~master_mode;
endmodule

// File: acrt_top_asserts.sv
// port-level assertions for the conversion sequencer
`timescale 1ns/10ps
module acrt_checker #(
  parameter int DATA_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic conversion_start_n,
  input wire logic chip_select_n,
  input wire logic serial_parallel_select,
  input wire logic read_timing_select,
  input wire logic clock_source_select,
  input wire logic [1:0] serial_clock_divider_select,
  input wire logic busy,
  input wire logic [DATA_WIDTH-1:0] data_bus_out,
  input wire logic data_bus_oe_n,
  input wire logic serial_data_oe_n,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe_n,
  input wire logic frame_sync_out,
  input wire logic frame_sync_oe_n
);
  logic mst;
  logic rac;
  logic dur;
  logic half2;
  assign mst = serial_parallel_select && !clock_source_select;
  assign rac = mst && !read_timing_select;
  assign dur = mst && read_timing_select;
  assign half2 = rac && serial_clock_divider_select == 2'h3;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  busy_rise_a: assert property ($fell(conversion_start_n) && !busy |=> busy)
    else $error("busy late after start");
  // a stalled fifo keeps busy up on purpose, so only a selected host is held to the bound
  busy_max_a: assert property ($rose(busy) && !rac && !chip_select_n |-> ##[1:12] !busy)
    else $error("busy too long");
  data_ahead_a: assert property ($fell(busy) && !serial_parallel_select |-> $stable(data_bus_out))
    else $error("data moved as busy fell");
  during_sync_a: assert property ($rose(frame_sync_out) && dur |-> $past(busy, 5) && !$past(busy, 7))
    else $error("frame start off in read during");
  sclk_half_a: assert property ($rose(serial_clock_out) |=> serial_clock_out == half2)
    else $error("serial clock high phase wrong");
  rac_sync_a: assert property ($rose(busy) && rac && !chip_select_n |-> ##10 !frame_sync_out ##1 frame_sync_out)
    else $error("frame start off in read after");
  sync_busy_a: assert property ($fell(frame_sync_out) && rac |-> busy ##1 busy ##1 !busy)
    else $error("busy did not follow frame end");
  cs_release_a: assert property (chip_select_n |-> frame_sync_oe_n && serial_clock_oe_n && serial_data_oe_n)
    else $error("serial pins driven while deselected");
  master_drive_a: assert property (!chip_select_n && mst |-> !serial_clock_oe_n && !frame_sync_oe_n)
    else $error("master clock not driven");
  port_sel_a: assert property (!chip_select_n |-> data_bus_oe_n == serial_parallel_select && serial_data_oe_n != data_bus_oe_n)
    else $error("wrong port enabled");
endmodule
bind acrt_top acrt_checker #(.DATA_WIDTH(DATA_WIDTH)) acrt_checker_i (
  .clk(clk), .reset(reset), .conversion_start_n(conversion_start_n), .chip_select_n(chip_select_n),
  .serial_parallel_select(serial_parallel_select), .read_timing_select(read_timing_select),
  .clock_source_select(clock_source_select), .serial_clock_divider_select(serial_clock_divider_select),
  .busy(busy), .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n), .serial_data_oe_n(serial_data_oe_n),
  .serial_clock_out(serial_clock_out), .serial_clock_oe_n(serial_clock_oe_n), .frame_sync_out(frame_sync_out),
  .frame_sync_oe_n(frame_sync_oe_n)
);

// File: acrt_host_model.sv
// host-side model: slave serial reader and master frame capture
`timescale 1ns/10ps
module acrt_host_model (
  input wire logic clk,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n,
  input wire logic serial_clock_out,
  input wire logic frame_sync_out,
  output logic external_serial_clock
);
  logic sdo_reg = 1'h0;
  logic sdo_pin;
  int cyc;
  // a released data line reads as the inverse of its last bit, so a stale bit never passes
  always @(posedge clk)
  begin
    if (!serial_data_oe_n)
      sdo_reg <= serial_data_out;
  end
  assign sdo_pin = serial_data_oe_n ? ~sdo_reg : serial_data_out;
  initial external_serial_clock = 1'h0;

  task automatic step();
    @(posedge clk);
    #1 cyc++;
  endtask

  // slow is cycles per clock phase; the clock rests low between words
  task automatic read_slave(input int slow, output logic [15:0] w);
    w = 16'h0000;
    repeat (3) step();
    for (int i = 0; i < 16; i++)
    begin
      repeat (slow) step();
      w = {w[14:0], sdo_pin};
      external_serial_clock = 1'h1;
      repeat (slow) step();
      external_serial_clock = 1'h0;
    end
  endtask

  task automatic read_master(output logic [15:0] w, output int per, output int tail);
    int rises;
    int last;
    logic prev;
    w = 16'h0000;
    rises = 0;
    last = 0;
    prev = 1'h0;
    per = 0;
    tail = 0;
    cyc = 0;
    while (frame_sync_out !== 1'h1 && cyc < 400)
      step();
    while (rises < 16 && cyc < 800)
    begin
      if (serial_clock_out && !prev)
      begin
        w = {w[14:0], sdo_pin};
        per = (rises == 1) ? cyc - last : per;
        last = cyc;
        rises++;
      end
      prev = serial_clock_out;
      step();
    end
    while (serial_clock_out && cyc < 800)
      step();
    while (frame_sync_out && cyc < 800)
    begin
      step();
      tail++;
    end
  endtask
endmodule

// File: adc_conversion_and_readout_timing_test.sv
// self-checking bench for the conversion and readout sequencer
`timescale 1ns/10ps
module adc_conversion_and_readout_timing_test;
  localparam int CONV = 9;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic clk_en = 1'h1;
  logic conversion_start_n = 1'h1;
  logic chip_select_n = 1'h1;
  logic serial_parallel_select = 1'h0;
  logic read_timing_select = 1'h0;
  logic clock_source_select = 1'h0;
  logic [1:0] serial_clock_divider_select = 2'h0;
  logic [15:0] conversion_result = 16'h0000;
  logic serial_data_in = 1'h0;
  logic external_serial_clock;
  logic busy;
  logic [15:0] data_bus_out;
  logic data_bus_oe_n;
  logic serial_data_out;
  logic serial_data_oe_n;
  logic serial_clock_out;
  logic serial_clock_oe_n;
  logic frame_sync_out;
  logic frame_sync_oe_n;
  logic [15:0] word;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int busy_len;
  int per;
  int tail;

  always #50 clk = ~clk;

  acrt_top #(.CONV_CYCLES(CONV)) acrt_top_i (
    .clk(clk), .reset(reset), .clk_en(clk_en), .conversion_start_n(conversion_start_n),
    .chip_select_n(chip_select_n), .serial_parallel_select(serial_parallel_select),
    .read_timing_select(read_timing_select), .clock_source_select(clock_source_select),
    .serial_clock_divider_select(serial_clock_divider_select), .conversion_result(conversion_result),
    .external_serial_clock(external_serial_clock), .serial_data_in(serial_data_in), .busy(busy),
    .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .serial_clock_out(serial_clock_out),
    .serial_clock_oe_n(serial_clock_oe_n), .frame_sync_out(frame_sync_out), .frame_sync_oe_n(frame_sync_oe_n)
  );
  acrt_host_model acrt_host_model_i (
    .clk(clk), .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
    .serial_clock_out(serial_clock_out), .frame_sync_out(frame_sync_out),
    .external_serial_clock(external_serial_clock)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // glitch drops start once more while busy; that edge must be ignored
  task automatic convert(input logic [15:0] v, input bit glitch, input int limit, output int n);
    conversion_result = v;
    conversion_start_n = 1'h0;
    @(posedge clk);
    #1 conversion_start_n = 1'h1;
    check("busy rise", 1, busy);
    n = 1;
    while (busy === 1'h1 && n < limit)
    begin
      @(posedge clk);
      #1 conversion_start_n = !(glitch && n == 4);
      n += (busy === 1'h1);
    end
    repeat (88) @(posedge clk);
    #1;
  endtask

  task automatic t_parallel();
    logic [15:0] v;
    chip_select_n = 1'h0;
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'hA5C3;
      convert(v, i == 2, 60, busy_len);
      check("parallel data", v, data_bus_out);
      check("busy bound", 1, busy_len <= 12);
      check("busy past conversion", 1, busy_len > CONV);
      check("parallel enable", 0, data_bus_oe_n);
      check("busy idle", 0, busy);
    end
    $display("parallel readout done");
  endtask

  task automatic t_fill();
    logic [15:0] w;
    chip_select_n = 1'h1;
    serial_parallel_select = 1'h1;
    clock_source_select = 1'h1;
    for (int i = 0; i < 33; i++)
    begin
      convert(16'h1000 + 16'(i), 0, 30, busy_len);
      check("busy with fifo full", i == 32, busy);
    end
    chip_select_n = 1'h0;
    for (int i = 0; i < 33; i++)
    begin
      acrt_host_model_i.read_slave((i % 2) ? 3 : 1, w);
      check("slave word", 16'h1000 + 16'(i), w);
    end
    check("stall cleared", 0, busy);
    $display("fifo fill and slave drain done");
  endtask

  task automatic t_master_rac();
    int typ_ns [4] = '{40, 70, 140, 280};
    int tail_ns [4] = '{3, 60, 140, 300};
    clock_source_select = 1'h0;
    for (int c = 0; c < 4; c++)
    begin
      serial_clock_divider_select = 2'(c);
      fork
        convert(16'hC35A ^ 16'(c), 0, 200, busy_len);
        acrt_host_model_i.read_master(word, per, tail);
      join
      check("master word", 16'hC35A ^ 16'(c), word);
      check("clock period", 2 * ((typ_ns[c] / 2 + 99) / 100), per);
      check("frame tail", (tail_ns[c] + 99) / 100, tail);
    end
    $display("master read after convert done");
  endtask

  task automatic t_during();
    read_timing_select = 1'h1;
    serial_clock_divider_select = 2'h3;
    convert(16'h5A3C, 0, 60, busy_len);
    fork
      convert(16'h0F0F, 0, 60, busy_len);
      acrt_host_model_i.read_master(word, per, tail);
    join
    check("previous word", 16'h5A3C, word);
    check("divider ignored", 2, per);
    check("busy bound", 1, busy_len <= 12);
    $display("master read during convert done");
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    #1 reset = 1'h0;
    t_parallel();
    t_fill();
    t_master_rac();
    t_during();
    wrap_up();
  end
endmodule
